// File: common/ivc_params.svh
// constants for the interrupt vector control block
// assumes an 8-bit internal i/o space and a 16-bit logical address space
`ifndef IVC_PARAMS_SVH
`define IVC_PARAMS_SVH

// ************************************************************
// register map and reset values
// ************************************************************
`define IVC_ADDR_VECTOR_LOW 8'h33
`define IVC_ADDR_FAULT_CTRL 8'h34
`define IVC_VEC_PAGE_RESET 8'h00
`define IVC_VEC_LOW_RESET 3'b000
`define IVC_LINE_EN_RESET 3'b111
`define IVC_READ_ZERO 8'h00

// ************************************************************
// field positions
// ************************************************************
`define IVC_TRAP_BIT 7
`define IVC_FAULT_POS_BIT 6
`define IVC_LINE_EN_MSB 2
`define IVC_VEC_LOW_MSB 7
`define IVC_VEC_LOW_LSB 5
`define IVC_CODE_WIDTH 5

// ************************************************************
// sources, index 0 has the highest priority
// ************************************************************
`define IVC_SRC_COUNT 12
`define IVC_SRC_WIDTH 4
`define IVC_SRC_TRAP 4'h0
`define IVC_SRC_NMI 4'h1
`define IVC_SRC_EXT0 4'h2
`define IVC_SRC_EXT1 4'h3
`define IVC_SRC_EXT2 4'h4
`define IVC_PERIPH_COUNT 7

// ************************************************************
// fixed restart addresses
// ************************************************************
`define IVC_RESTART_TRAP 16'h0000
`define IVC_RESTART_NMI 16'h0066
`define IVC_RESTART_EXT0_M1 16'h0038
`define IVC_EXT0_MODE0 2'b00
`define IVC_EXT0_MODE1 2'b01

`endif

// File: common/ivc_pkg.sv
// types shared by the interrupt vector control modules
// assumes ivc_params.svh supplies every number
package ivc_pkg;

    // ************************************************************
    // acceptance sequence, gray along idle-grant-wait-release
    // ************************************************************
    typedef enum logic [1:0] {
        IVC_IDLE = 2'b00,
        IVC_GRANT = 2'b01,
        IVC_WAIT = 2'b11,
        IVC_RELEASE = 2'b10
    } ivc_state_type;

    // ************************************************************
    // how the sequencer obtains the restart address
    // ************************************************************
    typedef enum logic [1:0] {
        IVC_KIND_RESTART = 2'b00,
        IVC_KIND_TABLE = 2'b01,
        IVC_KIND_TABLE_BUS_LOW = 2'b10,
        IVC_KIND_BUS_INSTR = 2'b11
    } ivc_kind_type;

endpackage

// File: common/ivc_arb_if.sv
// carrier between the top and its priority arbiter
// assumes the requester presents already masked requests
`timescale 1ns/1ns
`default_nettype none
`include "ivc_params.svh"

interface ivc_arb_if;
    logic [`IVC_SRC_COUNT-1:0] pending;
    logic grantValid;
    logic [`IVC_SRC_WIDTH-1:0] grantIdx;

    modport arbiter (
        input pending,
        output grantValid,
        output grantIdx
    );
    modport requester (
        output pending,
        input grantValid,
        input grantIdx
    );
endinterface

`default_nettype wire

// File: core/ivc_priority_arbiter.sv
// fixed priority pick among twelve masked requests
// assumes bit 0 of pending is the most urgent source
`timescale 1ns/1ns
`default_nettype none
`include "ivc_params.svh"

module ivc_priority_arbiter (
    ivc_arb_if.arbiter arb
);
    logic [`IVC_SRC_COUNT-1:0] blocked;
    logic [`IVC_SRC_COUNT-1:0] win;
    logic [`IVC_SRC_WIDTH-1:0] idxPart [`IVC_SRC_COUNT];

    // ************************************************************
    // one-hot winner and its index, one slice per source
    // ************************************************************
    // fixed priority
    genvar i;
    generate
        for (i = 0; i < `IVC_SRC_COUNT; i++) begin : g_src
            if (i == 0) begin : g_first
                assign blocked[i] = 1'b0;
                assign win[i] = arb.pending[i];
                assign idxPart[i] = '0;
            end else begin : g_rest
                assign blocked[i] = blocked[i-1] | arb.pending[i-1];
                assign win[i] = arb.pending[i] & ~blocked[i];
                assign idxPart[i] = idxPart[i-1] | (win[i] ? `IVC_SRC_WIDTH'(i) : '0);
            end
        end
    endgenerate

    // any request at all makes a winner
    assign arb.grantValid = |arb.pending;
    assign arb.grantIdx = idxPart[`IVC_SRC_COUNT-1];
endmodule

`default_nettype wire

// File: core/ivc_enable_flags.sv
// master and saved interrupt enable flags
// assumes each event input is a one-cycle pulse from the sequencer
`timescale 1ns/1ns
`default_nettype none

module ivc_enable_flags (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic disableInstr,
    input wire logic enableInstr,
    input wire logic nmiReturnInstr,
    input wire logic nmiTaken,
    input wire logic maskTaken,
    output logic masterEnable,
    output logic savedEnable
);
    logic master_q;
    logic master_d;
    logic saved_q;
    logic saved_d;

    // ************************************************************
    // next flag values, acceptance outranks instructions
    // ************************************************************
    always_comb begin
        master_d = master_q;
        saved_d = saved_q;
        if (nmiTaken) begin
            saved_d = master_q;
            master_d = 1'b0;
        end else if (maskTaken) begin
            master_d = 1'b0;
            saved_d = 1'b0;
        end else if (enableInstr) begin
            master_d = 1'b1;
            saved_d = 1'b1;
        end else if (disableInstr) begin
            master_d = 1'b0;
            saved_d = 1'b0;
        end else if (nmiReturnInstr) begin
            master_d = saved_q;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            master_q <= 1'b0;
            saved_q <= 1'b0;
        end else begin
            master_q <= master_d;
            saved_q <= saved_d;
        end
    end

    assign masterEnable = master_q;
    assign savedEnable = saved_q;
endmodule

`default_nettype wire

// File: core/ivc_top.sv
// interrupt vector control: vector registers, fault control, arbitration
// assumes a sequencer that pulses instruction events and accepts grants
//
// What this block does
// - twelve sources, four external and eight internal, fixed priority
// - vectored sources form a 16-bit table address for the restart fetch
// - vector page register is the table address upper byte
// - vector page reached only by accumulator loads, zero after reset
// - vector low bits 7..5 plus fixed five-bit source code form low byte
// - vector low register sits at i/o address 33H
// - vector low register clears on reset
// - fault control register at i/o 34H holds flag, position, line enables
// - undefined opcode fetch sets the fault flag in bit 7
// - software writing 0 clears the fault flag, writing 1 does nothing
// - read-only bit 6 tells whether second or third opcode byte failed
// - bits 2..0 enable external requests two, one and zero
// - master enable low refuses maskable sources, keeps nonmaskable and trap
// - disable clears both enables, enable sets both
// - nonmaskable acceptance copies master into saved then clears master
// - nonmaskable return copies saved into master, saved unchanged
// - reset clears both enable flags
// - other acceptances clear both flags, trap leaves them alone
// - accumulator loads of page or refresh copy master into parity flag
// - external request zero needs master enable and its line enable
// - trap pushes the program counter and restarts at address zero
`timescale 1ns/1ns
`default_nettype none
`include "ivc_params.svh"

module ivc_top (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ioWrEn,
    input wire logic ioRdEn,
    input wire logic [7:0] ioAddr,
    input wire logic [7:0] ioWrData,
    output logic [7:0] ioRdData,
    input wire logic vecPageWrEn,
    input wire logic [7:0] vecPageWrData,
    output logic [7:0] vecPage,
    input wire logic loadAFromVecPage,
    input wire logic loadAFromRefresh,
    output logic parityOverflow,
    input wire logic undefinedOpcode,
    input wire logic faultThirdByte,
    input wire logic disableInstr,
    input wire logic enableInstr,
    input wire logic nmiReturnInstr,
    input wire logic nmiRequest,
    input wire logic [`IVC_LINE_EN_MSB:0] extRequest,
    input wire logic [`IVC_PERIPH_COUNT-1:0] periphRequest,
    input wire logic [1:0] ext0Mode,
    input wire logic seqReady,
    input wire logic seqAck,
    output logic takeStrobe,
    output logic [`IVC_SRC_WIDTH-1:0] takeSource,
    output ivc_pkg::ivc_kind_type takeKind,
    output logic [15:0] takeAddr,
    output logic takePushPc,
    output logic busy,
    output logic masterEnable,
    output logic savedEnable,
    output logic trapFlag
);
    import ivc_pkg::*;

    // ************************************************************
    // declarations
    // ************************************************************
    ivc_arb_if arbBus ();
    logic [7:0] vecPage_q, vecPage_d;
    logic [`IVC_VEC_LOW_MSB:`IVC_VEC_LOW_LSB] vecLow_q, vecLow_d;
    logic trap_q, trap_d, faultPos_q, faultPos_d;
    logic [`IVC_LINE_EN_MSB:0] lineEn_q, lineEn_d;
    logic [7:0] rdData_q, rdData_d;
    logic pv_q, pv_d;
    logic trapPend_q, trapPend_d, nmiPend_q, nmiPend_d, nmiPrev_q, nmiPrev_d;
    ivc_state_type state_q, state_d;
    logic strobe_q, strobe_d, busy_q, busy_d;
    logic [`IVC_SRC_WIDTH-1:0] src_q, src_d;
    ivc_kind_type kind_q, kind_d;
    logic [15:0] addr_q, addr_d;
    logic push_q, push_d;
    logic master, saved;
    logic wrVecLow, wrFault, rdVecLow, rdFault;
    logic grantTrap, grantNmi, grantMask;
    logic [`IVC_CODE_WIDTH-1:0] srcCode;

    // ************************************************************
    // address decode of the internal i/o port
    // ************************************************************
    // vector low and fault control decode
    assign wrVecLow = ioWrEn && (ioAddr == `IVC_ADDR_VECTOR_LOW);
    assign rdVecLow = ioRdEn && (ioAddr == `IVC_ADDR_VECTOR_LOW);
    assign wrFault = ioWrEn && (ioAddr == `IVC_ADDR_FAULT_CTRL);
    assign rdFault = ioRdEn && (ioAddr == `IVC_ADDR_FAULT_CTRL);

    // ************************************************************
    // register file next values
    // ************************************************************
    always_comb begin
        vecPage_d = vecPage_q;
        vecLow_d = vecLow_q;
        trap_d = trap_q;
        faultPos_d = faultPos_q;
        lineEn_d = lineEn_q;
        rdData_d = rdData_q;
        pv_d = pv_q;
        if (vecPageWrEn) begin
            vecPage_d = vecPageWrData;
        end
        // only the top three bits are stored
        if (wrVecLow) begin
            vecLow_d = ioWrData[`IVC_VEC_LOW_MSB:`IVC_VEC_LOW_LSB];
        end
        if (wrFault) begin
            lineEn_d = ioWrData[`IVC_LINE_EN_MSB:0];
            if (!ioWrData[`IVC_TRAP_BIT]) begin
                trap_d = 1'b0;
            end
        end
        // set wins over a clearing write in the same cycle
        if (undefinedOpcode) begin
            trap_d = 1'b1;
            faultPos_d = faultThirdByte;
        end
        // reads return a fresh copy, unmapped addresses read zero
        if (rdVecLow) begin
            rdData_d = `IVC_READ_ZERO;
            rdData_d[`IVC_VEC_LOW_MSB:`IVC_VEC_LOW_LSB] = vecLow_q;
        end else if (rdFault) begin
            rdData_d = `IVC_READ_ZERO;
            rdData_d[`IVC_TRAP_BIT] = trap_q;
            rdData_d[`IVC_FAULT_POS_BIT] = faultPos_q;
            rdData_d[`IVC_LINE_EN_MSB:0] = lineEn_q;
        end else if (ioRdEn) begin
            rdData_d = `IVC_READ_ZERO;
        end
        if (loadAFromVecPage || loadAFromRefresh) begin
            pv_d = master;
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            vecPage_q <= `IVC_VEC_PAGE_RESET;
            vecLow_q <= `IVC_VEC_LOW_RESET;
            trap_q <= 1'b0;
            faultPos_q <= 1'b0;
            lineEn_q <= `IVC_LINE_EN_RESET;
            rdData_q <= `IVC_READ_ZERO;
            pv_q <= 1'b0;
        end else begin
            vecPage_q <= vecPage_d;
            vecLow_q <= vecLow_d;
            trap_q <= trap_d;
            faultPos_q <= faultPos_d;
            lineEn_q <= lineEn_d;
            rdData_q <= rdData_d;
            pv_q <= pv_d;
        end
    end

    // ************************************************************
    // request capture and masking
    // ************************************************************
    // nonmaskable is edge sensitive, so a held line asks only once
    always_comb begin
        trapPend_d = trapPend_q;
        nmiPend_d = nmiPend_q;
        nmiPrev_d = nmiRequest;
        if (grantTrap) begin
            trapPend_d = 1'b0;
        end
        if (grantNmi) begin
            nmiPend_d = 1'b0;
        end
        // new events win over the grant that consumes the old one
        if (undefinedOpcode) begin
            trapPend_d = 1'b1;
        end
        if (nmiRequest && !nmiPrev_q) begin
            nmiPend_d = 1'b1;
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            trapPend_q <= 1'b0;
            nmiPend_q <= 1'b0;
            nmiPrev_q <= 1'b0;
        end else begin
            trapPend_q <= trapPend_d;
            nmiPend_q <= nmiPend_d;
            nmiPrev_q <= nmiPrev_d;
        end
    end
    // external lines need line enable and master, peripherals need master only
    assign arbBus.pending = {periphRequest & {`IVC_PERIPH_COUNT{master}},
                             extRequest & lineEn_q & {(`IVC_LINE_EN_MSB + 1){master}},
                             nmiPend_q,
                             trapPend_q};
    ivc_priority_arbiter u_arbiter (
        .arb(arbBus.arbiter)
    );

    // ************************************************************
    // enable flags
    // ************************************************************
    assign grantTrap = (state_q == IVC_GRANT) && (src_q == `IVC_SRC_TRAP);
    assign grantNmi = (state_q == IVC_GRANT) && (src_q == `IVC_SRC_NMI);
    assign grantMask = (state_q == IVC_GRANT) && !grantTrap && !grantNmi;
    ivc_enable_flags u_flags (
        .sys_clk(sys_clk),
        .rst(rst),
        .disableInstr(disableInstr),
        .enableInstr(enableInstr),
        .nmiReturnInstr(nmiReturnInstr),
        .nmiTaken(grantNmi),
        .maskTaken(grantMask),
        .masterEnable(master),
        .savedEnable(saved)
    );

    // ************************************************************
    // acceptance sequence and restart address
    // ************************************************************
    // fixed low code per vectored source, two bytes per table entry
    assign srcCode = `IVC_CODE_WIDTH'({arbBus.grantIdx - `IVC_SRC_EXT1, 1'b0});
    always_comb begin
        state_d = state_q;
        strobe_d = 1'b0;
        src_d = src_q;
        kind_d = kind_q;
        addr_d = addr_q;
        push_d = push_q;
        case (state_q)
            IVC_IDLE: begin
                if (seqReady && arbBus.grantValid) begin
                    state_d = IVC_GRANT;
                    strobe_d = 1'b1;
                    src_d = arbBus.grantIdx;
                    push_d = 1'b1;
                    // table address from page, low bits and code
                    kind_d = IVC_KIND_TABLE;
                    addr_d = {vecPage_q, vecLow_q, srcCode};
                    if (arbBus.grantIdx == `IVC_SRC_TRAP) begin
                        // trap restarts at zero with pc pushed
                        kind_d = IVC_KIND_RESTART;
                        addr_d = `IVC_RESTART_TRAP;
                    end else if (arbBus.grantIdx == `IVC_SRC_NMI) begin
                        kind_d = IVC_KIND_RESTART;
                        addr_d = `IVC_RESTART_NMI;
                    end else if (arbBus.grantIdx == `IVC_SRC_EXT0) begin
                        if (ext0Mode == `IVC_EXT0_MODE0) begin
                            // the bus supplies an instruction, no automatic push
                            kind_d = IVC_KIND_BUS_INSTR;
                            addr_d = `IVC_RESTART_TRAP;
                            push_d = 1'b0;
                        end else if (ext0Mode == `IVC_EXT0_MODE1) begin
                            kind_d = IVC_KIND_RESTART;
                            addr_d = `IVC_RESTART_EXT0_M1;
                        end else begin
                            // page byte high, low byte follows from the bus
                            kind_d = IVC_KIND_TABLE_BUS_LOW;
                            addr_d = {vecPage_q, 8'h00};
                        end
                    end
                end
            end
            IVC_GRANT: begin
                state_d = IVC_WAIT;
            end
            IVC_WAIT: begin
                // the sequencer holds off until its push and fetch are done
                if (seqAck) begin
                    state_d = IVC_RELEASE;
                end
            end
            IVC_RELEASE: begin
                state_d = IVC_IDLE;
            end
            default: begin
                state_d = IVC_IDLE;
            end
        endcase
        busy_d = (state_d != IVC_IDLE);
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= IVC_IDLE;
            busy_q <= 1'b0;
            strobe_q <= 1'b0;
            src_q <= `IVC_SRC_TRAP;
            kind_q <= IVC_KIND_RESTART;
            addr_q <= `IVC_RESTART_TRAP;
            push_q <= 1'b0;
        end else begin
            state_q <= state_d;
            busy_q <= busy_d;
            strobe_q <= strobe_d;
            src_q <= src_d;
            kind_q <= kind_d;
            addr_q <= addr_d;
            push_q <= push_d;
        end
    end
    // ************************************************************
    // outputs, every one a flip-flop
    // ************************************************************
    assign ioRdData = rdData_q;
    assign vecPage = vecPage_q;
    assign parityOverflow = pv_q;
    assign takeStrobe = strobe_q;
    assign takeSource = src_q;
    assign takeKind = kind_q;
    assign takeAddr = addr_q;
    assign takePushPc = push_q;
    assign busy = busy_q;
    assign masterEnable = master;
    assign savedEnable = saved;
    assign trapFlag = trap_q;
endmodule

`default_nettype wire

// File: verification/ivc_asserts.sv
// port assertions for ivc_top
// assumes one clock domain with async reset rst
`timescale 1ns/1ns
`default_nettype none

module ivc_asserts (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic enableInstr,
    input wire logic disableInstr,
    input wire logic nmiReturnInstr,
    input wire logic loadAFromVecPage,
    input wire logic loadAFromRefresh,
    input wire logic undefinedOpcode,
    input wire logic parityOverflow,
    input wire logic takeStrobe,
    input wire logic [3:0] takeSource,
    input wire logic masterEnable,
    input wire logic savedEnable,
    input wire logic trapFlag
);
    // ********
    // checks
    // ********
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // grants outrank instruction events on the flags, so those cycles are left out
    logic calm;
    assign calm = !takeStrobe;
    sequence sQuiet;
        !takeStrobe [*3];
    endsequence
    sequence sTake(src);
        takeStrobe && takeSource == src;
    endsequence

    AST_SPACING: assert property (takeStrobe |=> sQuiet)
        else $error("grants too close");
    AST_ENABLE: assert property (enableInstr && calm |=> masterEnable && savedEnable)
        else $error("enable flags not set");
    AST_DISABLE: assert property (
        disableInstr && !enableInstr && calm |=> !masterEnable && !savedEnable)
        else $error("enable flags not cleared");
    AST_NMI: assert property (
        sTake(1) |=> !masterEnable && savedEnable == $past(masterEnable))
        else $error("nonmaskable entry flags wrong");
    AST_MASKED: assert property (takeStrobe && takeSource > 1 |=> !masterEnable && !savedEnable)
        else $error("maskable entry flags wrong");
    AST_RETURN: assert property (
        nmiReturnInstr && !enableInstr && !disableInstr && calm
        |=> masterEnable == $past(savedEnable) && $stable(savedEnable))
        else $error("return flags wrong");
    AST_PARITY: assert property (
        loadAFromVecPage || loadAFromRefresh |=> parityOverflow == $past(masterEnable))
        else $error("parity flag wrong");
    AST_TRAP: assert property (undefinedOpcode |=> trapFlag ##1 trapFlag)
        else $error("fault flag not set");
endmodule

bind ivc_top ivc_asserts asrt (
    .sys_clk, .rst, .enableInstr, .disableInstr, .nmiReturnInstr, .loadAFromVecPage,
    .loadAFromRefresh, .undefinedOpcode, .parityOverflow, .takeStrobe, .takeSource,
    .masterEnable, .savedEnable, .trapFlag
);
`default_nettype wire

// File: verification/ivc_seq_model.sv
// sequencer model: acknowledges each grant once
// assumes takeStrobe is a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none

module ivc_seq_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic takeStrobe,
    output logic seqReady,
    output logic seqAck
);
    logic [2:0] cnt_q;
    // ack one or five cycles after a grant; not ready meanwhile
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 3'h0;
        end else if (takeStrobe) begin
            cnt_q <= slow ? 3'h5 : 3'h1;
        end else if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
        end
    end
    assign seqAck = cnt_q == 3'h1;
    assign seqReady = cnt_q == 3'h0;
endmodule
`default_nettype wire

// File: verification/ivc_top_test.sv
// self-checking bench for ivc_top against a flag and register model
// assumes ivc_seq_model answers the grants
`timescale 1ns/1ns
`default_nettype none

module ivc_top_test;
    import ivc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ioWrEn = 1'b0, ioRdEn = 1'b0, faultThirdByte = 1'b0, nmiRequest = 1'b0, slow = 1'b0;
    logic [7:0] ioAddr = 8'h00, ioWrData = 8'h00, pgData = 8'h00;
    logic [6:0] ev = 7'h00, periphRequest = 7'h00;
    logic [2:0] extRequest = 3'h0;
    logic [1:0] ext0Mode = 2'h0;
    logic [7:0] ioRdData, vecPage;
    logic [3:0] takeSource;
    logic [15:0] takeAddr;
    ivc_kind_type takeKind;
    logic seqReady, seqAck, takeStrobe, takePushPc, busy, me, se, trapFlag, parity;
    ivc_kind_type kinds [3] = '{IVC_KIND_BUS_INSTR, IVC_KIND_RESTART, IVC_KIND_TABLE_BUS_LOW};
    int failures = 0;
    int cmpCount = 0;
    bit [31:0] seed = 32'h0000_2D4A;
    // reference model state
    bit mM, mS, mTr, mUf, mPar;
    bit [2:0] mLe = 3'h7, mVl;
    bit [7:0] mPg;

    ivc_top dut (
        .sys_clk, .rst, .ioWrEn, .ioRdEn, .ioAddr, .ioWrData, .ioRdData,
        .vecPageWrEn(ev[6]), .vecPageWrData(pgData), .vecPage, .loadAFromVecPage(ev[3]),
        .loadAFromRefresh(ev[4]), .parityOverflow(parity), .undefinedOpcode(ev[5]),
        .faultThirdByte, .disableInstr(ev[0]), .enableInstr(ev[1]), .nmiReturnInstr(ev[2]),
        .nmiRequest, .extRequest, .periphRequest, .ext0Mode, .seqReady, .seqAck, .takeStrobe,
        .takeSource, .takeKind, .takeAddr, .takePushPc, .busy, .masterEnable(me),
        .savedEnable(se), .trapFlag
    );
    ivc_seq_model seq (.sys_clk, .rst, .slow, .takeStrobe, .seqReady, .seqAck);

    // ********
    // helpers
    // ********
    initial forever #4 sys_clk = ~sys_clk;

    task automatic stop_test;
        if (failures == 0 && cmpCount > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(string n, logic [15:0] got, logic [15:0] exp);
        cmpCount++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, exp, got);
        end
    endtask

    function automatic bit [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    // inputs move 1 ns after the edge so the design samples settled values
    task automatic step;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic io(bit w, bit [7:0] a, bit [7:0] d);
        bit [7:0] e;
        ioWrEn = w;
        ioRdEn = !w;
        ioAddr = a;
        ioWrData = d;
        step;
        ioWrEn = 1'b0;
        ioRdEn = 1'b0;
        if (w && a == 8'h33) mVl = d[7:5];
        if (w && a == 8'h34) {mTr, mLe} = {mTr & d[7], d[2:0]};
        e = a == 8'h33 ? {mVl, 5'h00} : a == 8'h34 ? {mTr, mUf, 3'h0, mLe} : 8'h00;
        if (!w) chk("ioRdData", ioRdData, e);
        step;
    endtask

    // one instruction event; model applies its effect first
    task automatic pulse(int i);
        ev[i] = 1'b1;
        if (i == 0) {mM, mS} = 2'h0;
        if (i == 1) {mM, mS} = 2'h3;
        if (i == 2) mM = mS;
        if (i == 3 || i == 4) mPar = mM;
        if (i == 5) {mTr, mUf} = {1'b1, faultThirdByte};
        if (i == 6) mPg = pgData;
        step;
        ev = 7'h00;
        chk("master", me, mM);
        chk("saved", se, mS);
        chk("parity", parity, mPar);
        chk("trapFlag", trapFlag, mTr);
        chk("vecPage", vecPage, mPg);
        step;
    endtask

    task automatic none;
        logic seen;
        seen = 1'b0;
        repeat (8) begin
            step;
            seen |= takeStrobe;
        end
        chk("takeStrobe", seen, 1'b0);
    endtask

    // wait for a grant, check it, then let the handshake finish
    task automatic take(bit [3:0] src, ivc_kind_type k, bit [15:0] a);
        int n;
        n = 0;
        while (takeStrobe !== 1'b1 && n < 20) begin
            step;
            n++;
        end
        chk("takeStrobe", takeStrobe, 1'b1);
        chk("busy", busy, 1'b1);
        extRequest = 3'h0;
        periphRequest = 7'h00;
        nmiRequest = 1'b0;
        chk("takeSource", takeSource, src);
        chk("takeKind", takeKind, k);
        chk("takeAddr", takeAddr, a);
        chk("takePushPc", takePushPc, !(src == 4'h2 && ext0Mode == 2'h0));
        if (src == 4'h1) {mM, mS} = {1'b0, mM};
        if (src > 4'h1) {mM, mS} = 2'h0;
        step;
        chk("master", me, mM);
        chk("saved", se, mS);
        while (busy !== 1'b0 && n < 40) begin
            step;
            n++;
        end
        chk("busy", busy, 1'b0);
    endtask

    // watchdog well beyond the few hundred cycles the run needs
    initial begin
        #80000;
        failures++;
        stop_test;
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        chk("master", me, 1'b0);
        chk("saved", se, 1'b0);
        for (int i = 0; i < 16; i++) begin
            io(i[0], 8'h33 + 8'(i[2:1]), rnd());
        end
        // faults with the master enable set must leave both flags alone
        pulse(1);
        for (int i = 0; i < 2; i++) begin
            faultThirdByte = i[0];
            pulse(5);
            take(4'h0, IVC_KIND_RESTART, 16'h0000);
            io(0, 8'h34, 8'h00);
            io(1, 8'h34, {~i[0], 7'h07});
            io(0, 8'h34, 8'h00);
        end
        pgData = rnd();
        pulse(6);
        pulse(3);
        pulse(0);
        pulse(4);
        periphRequest = 7'h7F;
        extRequest = 3'h7;
        none();
        io(1, 8'h34, 8'h00);
        periphRequest = 7'h00;
        pulse(1);
        none();
        extRequest = 3'h0;
        io(1, 8'h34, 8'h07);
        for (int s = 3; s < 12; s++) begin
            slow = s[0];
            io(1, 8'h33, rnd());
            pulse(1);
            periphRequest[6] = 1'b1;
            if (s < 5) extRequest[s - 2] = 1'b1;
            if (s > 4) periphRequest[s - 5] = 1'b1;
            take(4'(s), IVC_KIND_TABLE, {mPg, mVl, 5'(2 * (s - 3))});
        end
        for (int m = 0; m < 3; m++) begin
            ext0Mode = 2'(m);
            pulse(1);
            extRequest = 3'h1;
            take(4'h2, kinds[m], m == 2 ? {mPg, 8'h00} : 16'(m) * 16'h0038);
        end
        for (int i = 0; i < 2; i++) begin
            pulse(i);
            nmiRequest = 1'b1;
            take(4'h1, IVC_KIND_RESTART, 16'h0066);
            pulse(2);
        end
        stop_test;
    end
endmodule
`default_nettype wire
